// ---- src/aac_decode.v ----
// Decode and execute of keep-carry add, AND, call and carry-clear instructions
`timescale 1ns/1ps
`include "aac_map.vh"
////////////////////////////////////////////////////////////////////////////////
// Timing in brief:
//   - A word is taken at the rising edge that sees i_instr_valid high.
//   - Its results show one cycle later; there is no stall and no bubble.
//   - Memory and working register read data must belong to the same word.
//   - Write strobes and the stack push stand for one cycle only.
//   - Addresses and write data hold after a strobe until the next write.
//   - Words that this block does not decode only step the counter.
// Limitation: carry is never set here; another block owns the carrying
// add forms, so the keep-carry forms simply leave the flag alone.
// Back-to-back words are fine because the accumulator feeds the next
// sum directly from its register.
////////////////////////////////////////////////////////////////////////////////
module aac_decode
(
  input  wire        i_clk_sys,
  input  wire        i_srst,
  input  wire        i_instr_valid,
  input  wire [15:0] i_instr,
  input  wire [3:0]  i_mem_rdata,
  input  wire [3:0]  i_wr_rdata,
  output reg  [3:0]  o_arith_result_reg,
  output reg         o_carry_flag,
  output reg         o_zero_flag,
  output reg  [10:0] o_program_counter,
  output reg  [6:0]  o_mem_addr,
  output reg  [3:0]  o_mem_wdata,
  output reg         o_mem_we,
  output reg  [3:0]  o_wr_addr,
  output reg  [3:0]  o_wr_wdata,
  output reg         o_wr_we,
  output reg  [10:0] o_stack_wdata,
  output reg         o_stack_push
);

  ////////////////////////////////////////////////////////////////////////////
  // Operand fields; memory and register read data belong to the current word
  wire [3:0] imm    = i_instr[`AAC_IMM_HI:`AAC_IMM_LO];
  wire [3:0] wr_idx = i_instr[`AAC_WR_HI:`AAC_WR_LO];
  wire [7:0] op8    = i_instr[15:8];
  wire [8:0] op9    = i_instr[15:7];

  wire add_keep_carry_imm       = (op8 == `AAC_OP8_ADD_IMM);
  wire add_keep_carry_writeback_imm = (op8 == `AAC_OP8_ADDWB_IMM);
  wire add_keep_carry_writeback_mem = (op9 == `AAC_OP9_ADDWB_MEM);
  wire and_to_result_imm        = (op8 == `AAC_OP8_AND_IMM);
  wire and_to_result_mem        = (op8 == `AAC_OP8_AND_MEM);
  wire and_writeback_imm        = (op8 == `AAC_OP8_ANDWB_IMM);
  wire and_writeback_mem        = (op9 == `AAC_OP9_ANDWB_MEM);
  wire call_instr               = (i_instr[15:11] == `AAC_OP5_CALL);
  wire carry_clear_instr        = (i_instr == `AAC_OP16_CLR_CARRY);

  ////////////////////////////////////////////////////////////////////////////
  // Result selection; a 4-bit sum drops carry since these forms keep it
  reg [3:0] next_result;
  reg       next_load;
  always @*
  begin
    next_result = 4'h0;
    next_load   = 1'b0;
    if (add_keep_carry_imm || add_keep_carry_writeback_imm)
    begin
      next_result = i_wr_rdata + imm;
      next_load   = 1'b1;
    end
    else if (add_keep_carry_writeback_mem)
    begin
      next_result = i_mem_rdata + o_arith_result_reg;
      next_load   = 1'b1;
    end
    else if (and_to_result_imm || and_writeback_imm)
    begin
      next_result = i_wr_rdata & imm;
      next_load   = 1'b1;
    end
    else if (and_to_result_mem || and_writeback_mem)
    begin
      next_result = i_mem_rdata & o_arith_result_reg;
      next_load   = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write-back groups, shared by the port processes below
  wire mem_writeback = add_keep_carry_writeback_mem | and_writeback_mem;
  wire wr_writeback  = add_keep_carry_writeback_imm | and_writeback_imm;
  wire exec          = i_instr_valid;

  ////////////////////////////////////////////////////////////////////////////
  // Counter step, used for both the fall-through and the return address
  function [10:0] aac_pc_step;
    input [10:0] pc;
    begin
      aac_pc_step = pc + 11'h001;
    end
  endfunction

  // Zero test on a 4-bit result
  function aac_is_zero;
    input [3:0] value;
    begin
      aac_is_zero = (value == 4'h0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and zero flag; words that load nothing leave both alone
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_arith_result_reg <= 4'h0;
      o_zero_flag        <= 1'b0;
    end
    else if (exec && next_load)
    begin
      o_arith_result_reg <= next_result;
      o_zero_flag        <= aac_is_zero(next_result);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Carry flag; no form in this block sets it, so only the clear acts.
  // The keep-carry forms never reach this process, which is how they keep it.
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_carry_flag <= 1'b0;
    else if (exec && carry_clear_instr)
      o_carry_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter; a call replaces the step, unknown words only step
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
      o_program_counter <= `AAC_PC_RESET;
    else if (exec && call_instr)
      o_program_counter <= i_instr[`AAC_TGT_HI:0];
    else if (exec)
      o_program_counter <= aac_pc_step(o_program_counter);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory port; address and data hold after the strobe so the
  // neighbouring memory may sample them late in the cycle
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_mem_addr  <= 7'h00;
      o_mem_wdata <= 4'h0;
      o_mem_we    <= 1'b0;
    end
    else
    begin
      o_mem_we <= exec & mem_writeback;
      if (exec && mem_writeback)
      begin
        o_mem_addr  <= i_instr[`AAC_MEM_HI:0];
        o_mem_wdata <= next_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register port; same hold behaviour as the memory port
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_wr_addr  <= 4'h0;
      o_wr_wdata <= 4'h0;
      o_wr_we    <= 1'b0;
    end
    else
    begin
      o_wr_we <= exec & wr_writeback;
      if (exec && wr_writeback)
      begin
        o_wr_addr  <= wr_idx;
        o_wr_wdata <= next_result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack port; the pushed value is the step of the counter that
  // the call itself occupies, taken before the jump lands
  always @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_stack_wdata <= 11'h000;
      o_stack_push  <= 1'b0;
    end
    else
    begin
      o_stack_push <= exec & call_instr;
      if (exec && call_instr)
        o_stack_wdata <= aac_pc_step(o_program_counter);
    end
  end

endmodule // aac_decode

// ---- src/aac_map.vh ----
// Opcode field positions, match patterns and reset values for the decoder
`ifndef AAC_MAP_VH
`define AAC_MAP_VH
`define AAC_OP8_ADD_IMM    8'h2C
`define AAC_OP8_ADDWB_IMM  8'h2D
`define AAC_OP8_AND_IMM    8'h2E
`define AAC_OP8_ANDWB_IMM  8'h2F
`define AAC_OP8_AND_MEM    8'h2A
`define AAC_OP9_ADDWB_MEM  9'h052
`define AAC_OP9_ANDWB_MEM  9'h056
`define AAC_OP5_CALL       5'h0C
`define AAC_OP16_CLR_CARRY 16'h5000
`define AAC_IMM_HI         7
`define AAC_IMM_LO         4
`define AAC_WR_HI          3
`define AAC_WR_LO          0
`define AAC_MEM_HI         6
`define AAC_TGT_HI         10
`define AAC_PC_RESET       11'h000
`endif

// ---- verification/aac_decode_asserts.sv ----
// Port assertions for the keep-carry add, AND, call and carry-clear decoder
`timescale 1ns/1ps
module aac_decode_chk
(input logic i_clk_sys, i_srst, i_instr_valid, input logic [15:0] i_instr,
 input logic [3:0] i_mem_rdata, i_wr_rdata, o_arith_result_reg, input logic o_carry_flag,
 input logic o_zero_flag, input logic [10:0] o_program_counter, input logic [6:0] o_mem_addr,
 input logic [3:0] o_mem_wdata, input logic o_mem_we, input logic [3:0] o_wr_addr, o_wr_wdata,
 input logic o_wr_we, input logic [10:0] o_stack_wdata, input logic o_stack_push);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  // Short aliases keep each property on two or three lines
  wire v = i_instr_valid;
  wire [15:0] n = i_instr;
  a_add_imm_sum: assert property (v && n[15:9] == 7'h16 |=> o_arith_result_reg ==
    $past(i_wr_rdata) + $past(n[7:4])) else $error("add immediate sum wrong");
  a_and_imm_res: assert property (v && n[15:9] == 7'h17 |=> o_arith_result_reg ==
    ($past(i_wr_rdata) & $past(n[7:4]))) else $error("and immediate result wrong");
  a_wr_back_pulse: assert property (v && (n[15:8] == 8'h2D || n[15:8] == 8'h2F)
    |=> o_wr_we && o_wr_addr == $past(n[3:0])) else $error("register write-back missing");
  a_mem_back_pulse: assert property (v && (n[15:7] == 9'h052 || n[15:7] == 9'h056)
    |=> o_mem_we && o_mem_addr == $past(n[6:0])) else $error("memory write-back missing");
  a_zero_tracks: assert property (v && (n[15:10] == 6'h0B || n[15:8] == 8'h2A ||
    n[15:7] == 9'h052 || n[15:7] == 9'h056) |=>
    o_zero_flag == (o_arith_result_reg == 4'h0)) else $error("zero flag wrong");
  a_carry_kept: assert property (v && n[15:12] == 4'h2 |=> $stable(o_carry_flag))
    else $error("carry changed");
  a_call_push: assert property (v && n[15:11] == 5'h0C |=> o_stack_push &&
    o_stack_wdata == $past(o_program_counter) + 11'h001 && o_program_counter == $past(n[10:0]))
    else $error("call push wrong");
  a_clr_carry_only: assert property (v && n == 16'h5000 |=> !o_carry_flag &&
    $stable(o_arith_result_reg) && $stable(o_zero_flag)) else $error("carry clear wrong");
endmodule // aac_decode_chk

// ---- verification/aac_decode_tb.sv ----
// Directed testbench for the keep-carry add, AND, call and carry-clear decoder
`timescale 1ns/1ps
module aac_decode_tb;
  logic clk = 0, srst = 1, vld = 0;
  logic [15:0] ins = 16'h0000;
  logic [3:0] mrd = 4'h0, wrd = 4'h0;
  wire [3:0] acc, mwd, wa, wwd;
  wire cf, zf, mwe, wwe, push;
  wire [10:0] pc, stk;
  wire [6:0] ma;
  logic [10:0] p;
  int err_count = 0, compares = 0;
  aac_decode i_dut (.i_clk_sys(clk), .i_srst(srst), .i_instr_valid(vld), .i_instr(ins),
    .i_mem_rdata(mrd), .i_wr_rdata(wrd), .o_arith_result_reg(acc), .o_carry_flag(cf),
    .o_zero_flag(zf), .o_program_counter(pc), .o_mem_addr(ma), .o_mem_wdata(mwd),
    .o_mem_we(mwe), .o_wr_addr(wa), .o_wr_wdata(wwd), .o_wr_we(wwe), .o_stack_wdata(stk),
    .o_stack_push(push));
  always #50 clk = ~clk;
  // One instruction, checked after the edge that executes it has landed
  task run(input [15:0] i, input [3:0] m, input [3:0] w);
    @(posedge clk);
    vld <= 1'b1; ins <= i; mrd <= m; wrd <= w;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task chk(input [10:0] g, input [10:0] e);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task t_add;
    run(16'h2C35, 4'h0, 4'h4); chk(acc, 7); chk(zf, 0); chk(wwe, 0);
    run(16'h2D35, 4'h0, 4'h4); chk(wwd, 7); chk(wa, 5); chk(wwe, 1);
    run(16'h2911, 4'h9, 4'h0); chk(acc, 0); chk(zf, 1); chk(ma, 11'h11);
    chk(mwd, 0); chk(mwe, 1); chk(cf, 0);
    $display("add forms done");
  endtask
  task t_and;
    run(16'h2EC5, 4'h0, 4'hE); chk(acc, 4'hC); chk(zf, 0);
    run(16'h2A05, 4'h6, 4'h0); chk(acc, 4);
    run(16'h2B05, 4'h5, 4'h0); chk(mwd, 4); chk(mwe, 1); chk(acc, 4);
    run(16'h2F30, 4'h0, 4'h1); chk(wwd, 1); chk(wwe, 1); chk(acc, 1);
    $display("and forms done");
  endtask
  task t_call;
    p = pc;
    run(16'h6123, 4'h0, 4'h0); chk(stk, p + 11'h001); chk(push, 1); chk(pc, 11'h123);
    run(16'h5000, 4'h0, 4'h0); chk(cf, 0); chk(acc, 1); chk(pc, 11'h124);
    $display("call and carry clear done");
  endtask
  task t_misc;
    run(16'h2805, 4'h3, 4'h3); chk(acc, 1); chk(pc, 11'h125); chk(mwe, 0);
    chk(wwe, 0); chk(push, 0); chk(zf, 0);
    @(posedge clk); srst <= 1'b1;
    @(posedge clk); srst <= 1'b0;
    #1; chk(pc, 0); chk(acc, 0); chk(zf, 0); chk(cf, 0); chk(mwe, 0);
    run(16'h2C00, 4'h0, 4'h0); chk(acc, 0); chk(zf, 1); chk(pc, 11'h001);
    $display("refused word and reset done");
  endtask
  task give_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_add; t_and; t_call; t_misc;
    give_verdict;
  end
endmodule // aac_decode_tb
bind aac_decode aac_decode_chk i_chk (.*);
